// ==== design/uart_status_defs.svh ====
// Register offsets, field positions and reset values of the status block
`ifndef UART_STATUS_DEFS_SVH
`define UART_STATUS_DEFS_SVH
// Byte offsets on the register bus
`define OFS_DATA 12'h000
`define OFS_ERR_STATUS 12'h004
`define OFS_FLAGS 12'h018
`define OFS_LINE_CTRL 12'h02c
`define OFS_CTRL 12'h030
// Error status fields
`define ERR_OVERRUN 3
`define ERR_BREAK 2
`define ERR_PARITY 1
`define ERR_FRAMING 0
// Flag register fields
`define FLG_RING 8
`define FLG_TX_EMPTY 7
`define FLG_RX_FULL 6
`define FLG_TX_FULL 5
`define FLG_RX_EMPTY 4
`define FLG_BUSY 3
`define FLG_CARRIER 2
`define FLG_SET_READY 1
`define FLG_CLEAR_SEND 0
// Line control fields
`define LC_STICK_PAR 7
`define LC_FIFO_EN 4
`define LC_EVEN_PAR 2
`define LC_PAR_EN 1
// Control fields
`define CR_UART_EN 0
// Reset values
`define LINE_CTRL_RST 8'h00
`define CTRL_RST 1'h0
`define ERR_RST 4'h0
// Data bits per character
`define DATA_BITS 4'h8
`endif

// ==== design/uart_status_pkg.sv ====
// Types shared by the status block
package uart_status_pkg;
  // One receive FIFO entry: error tags travel with the character
  typedef struct packed {
    logic brk;
    logic par;
    logic frm;
    logic [7:0] data;
  } rx_entry_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BRKWAIT
  } rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } tx_state_t;
endpackage

// ==== design/uart_status_flags.sv ====
// UART receive error capture, line flags, FIFOs and serial engines
//
// Contract
// - Full receive FIFO at character end sets overrun
// - Overrun leaves stored FIFO contents untouched
// - Write to error location clears error bits
// - Line low a whole frame flags break
// - Break stores exactly one all-zero character
// - After break, wait for high then start
// - Parity mismatch against settings flags parity error
// - Low stop bit flags framing error
// - Each receive FIFO entry carries its own error tags
// - Ring and carrier flags are inverted inputs
// - Set-ready and clear-to-send flags are inverted inputs
// - Transmit empty follows holding register or FIFO
// - Receive full follows holding register or FIFO
// - Transmit full follows holding register or FIFO
// - Receive empty follows holding register or FIFO
// - Busy rises once transmit FIFO non-empty
// - Busy holds until last stop bit sent
// - FIFO disable makes single-entry holding registers
// - Even-parity setting selects odd or even
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "uart_status_defs.svh"

// ==========================================================================
// Small FIFO, flip-flop storage; capacity drops to one entry when limited
module uart_sf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic oneDeep, // Act as a single holding register
  input wire logic push, // Write request
  input wire logic [WIDTH-1:0] pushData, // Write data
  input wire logic pop, // Read request
  output logic [WIDTH-1:0] head, // Oldest entry
  output logic full, // No room left
  output logic empty // Nothing stored
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  wire doPush;
  wire doPop;

  // Full and empty are honest: refused pushes never touch storage
  // single entry
  assign full = oneDeep ? (count != '0) : (count == (AW+1)'(DEPTH));
  assign empty = (count == '0);
  assign doPush = push && !full;
  assign doPop = pop && !empty;
  assign head = store[rdPtr];

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) wrPtr <= wrPtr + 1'b1;
      if (doPop) rdPtr <= rdPtr + 1'b1;
      count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  // Storage has no reset; head shows store[rdPtr] even while empty, unwritten entries included
  always_ff @(posedge clk) begin
    if (doPush) store[wrPtr] <= pushData;
  end
endmodule // uart_sf_fifo

// ==========================================================================
module uart_status_flags #(
  parameter int DEPTH = 32, // FIFO entries when enabled
  parameter int BIT_CYCLES = 16 // Clock cycles per serial bit
) (
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [11:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [3:0] byteenable, // Avalon byte enables
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait request
  input wire logic serialIn, // Receive line
  output logic serialOut, // Transmit line
  input wire logic ringIn_n, // Ring indicator, active low
  input wire logic carrierIn_n, // Carrier detect, active low
  input wire logic setReadyIn_n, // Data set ready, active low
  input wire logic clearToSendIn_n // Clear to send, active low
);
  // Parameter checks
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end
  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bit
    $error("BIT_CYCLES out of range");
  end

  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2 - 1);

  // ========================================================================
  // Register bus slave
  logic [7:0] lineCtrl;
  logic uartEn;
  logic [3:0] errStatus;
  logic ovrFlag;
  wire request = read || write;
  wire accept = request && !waitrequest;
  wire hitData = (address == `OFS_DATA);
  wire hitErr = (address == `OFS_ERR_STATUS);
  wire hitFlags = (address == `OFS_FLAGS);
  wire hitLine = (address == `OFS_LINE_CTRL);
  wire hitCtrl = (address == `OFS_CTRL);
  wire dataRd = accept && read && hitData;
  wire dataWr = accept && write && hitData && byteenable[0];
  wire errClearWr = accept && write && hitErr;
  wire fifoOn = lineCtrl[`LC_FIFO_EN];
  wire parEn = lineCtrl[`LC_PAR_EN];
  wire evenPar = lineCtrl[`LC_EVEN_PAR];
  wire stickPar = lineCtrl[`LC_STICK_PAR];

  uart_status_pkg::rx_entry_t rxHead;
  logic rxFull, rxEmpty, txFull, txEmpty, busy;
  logic [7:0] txHead;
  wire [31:0] flagWord;
  wire [31:0] dataWord;
  wire [31:0] next_readdata;

  // Modem inputs are shown inverted, level for level
  // ring, carrier
  assign flagWord = {23'h000000, !ringIn_n, txEmpty, rxFull, txFull,
                     rxEmpty, busy, !carrierIn_n, !setReadyIn_n,
                     !clearToSendIn_n};
  // Data read carries the head entry's own tags
  // per-entry tags
  assign dataWord = {20'h00000, ovrFlag, rxHead.brk, rxHead.par,
                     rxHead.frm, rxHead.data};
  assign next_readdata = hitData ? dataWord :
                         hitErr ? {28'h0000000, errStatus} :
                         hitFlags ? flagWord :
                         hitLine ? {24'h000000, lineCtrl} :
                         hitCtrl ? {31'h00000000, uartEn} : 32'h00000000;

  // One wait cycle per access; data is latched with the answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= !(request && waitrequest);
      if (request && waitrequest) readdata <= next_readdata;
    end
  end

  // Control registers that steer the engines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lineCtrl <= `LINE_CTRL_RST;
      uartEn <= `CTRL_RST;
    end else begin
      if (accept && write && hitLine && byteenable[0])
        lineCtrl <= writedata[7:0];
      if (accept && write && hitCtrl && byteenable[0])
        uartEn <= writedata[`CR_UART_EN];
    end
  end

  // ========================================================================
  // Receiver
  uart_status_pkg::rx_state_t rxState;
  logic [15:0] rxCnt;
  logic [3:0] rxBitIdx;
  logic [7:0] rxShift;
  logic rxParBit;
  logic rxAnyHigh;
  logic rxDone;
  uart_status_pkg::rx_entry_t rxEntry;
  wire rxTick = (rxCnt == BIT_LAST);
  wire rxHalf = (rxCnt == BIT_HALF);
  wire rxPush = rxDone && !rxFull;
  wire rxOverrun = rxDone && rxFull;
  wire expPar = stickPar ? !evenPar : (evenPar ? ^rxShift : ~^rxShift);
  wire isBreak = !rxAnyHigh && !serialIn && !(parEn && rxParBit);

  // Frame sampler at mid-bit; rxDone pulses with a complete entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxState <= uart_status_pkg::RX_IDLE;
      rxCnt <= 16'h0000;
      rxBitIdx <= 4'h0;
      rxShift <= 8'h00;
      rxParBit <= 1'b0;
      rxAnyHigh <= 1'b0;
      rxDone <= 1'b0;
      rxEntry <= '0;
    end else begin
      rxDone <= 1'b0;
      rxCnt <= rxTick ? 16'h0000 : rxCnt + 16'h0001;
      unique case (rxState)
        uart_status_pkg::RX_IDLE: begin
          rxCnt <= 16'h0000;
          if (uartEn && !serialIn) rxState <= uart_status_pkg::RX_START;
        end
        uart_status_pkg::RX_START: begin
          if (rxHalf) begin
            rxCnt <= 16'h0000;
            rxBitIdx <= 4'h0;
            rxAnyHigh <= 1'b0;
            rxState <= serialIn ? uart_status_pkg::RX_IDLE
                                : uart_status_pkg::RX_DATA;
          end
        end
        uart_status_pkg::RX_DATA: begin
          if (rxTick) begin
            rxShift <= {serialIn, rxShift[7:1]};
            rxAnyHigh <= rxAnyHigh || serialIn;
            rxBitIdx <= rxBitIdx + 4'h1;
            if (rxBitIdx == `DATA_BITS - 4'h1)
              rxState <= parEn ? uart_status_pkg::RX_PARITY
                               : uart_status_pkg::RX_STOP;
          end
        end
        uart_status_pkg::RX_PARITY: begin
          if (rxTick) begin
            rxParBit <= serialIn;
            rxState <= uart_status_pkg::RX_STOP;
          end
        end
        uart_status_pkg::RX_STOP: begin
          if (rxTick) begin
            rxDone <= 1'b1;
            rxEntry.brk <= isBreak;
            rxEntry.data <= isBreak ? 8'h00 : rxShift;
            rxEntry.par <= !isBreak && parEn && (rxParBit != expPar);
            rxEntry.frm <= !isBreak && !serialIn;
            // hold off until line returns high
            rxState <= isBreak ? uart_status_pkg::RX_BRKWAIT
                               : uart_status_pkg::RX_IDLE;
          end
        end
        uart_status_pkg::RX_BRKWAIT: begin
          if (serialIn) rxState <= uart_status_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receive FIFO; a push while full is dropped, stored entries stay
  // contents kept on overrun
  uart_sf_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .oneDeep(!fifoOn),
    .push(rxPush),
    .pushData(rxEntry),
    .pop(dataRd),
    .head(rxHead),
    .full(rxFull),
    .empty(rxEmpty)
  );

  // ========================================================================
  // Error status: overrun on event, others taken from the read entry.
  // A setting event beats a clear in the same cycle.
  wire [3:0] errSet = {rxOverrun, dataRd && rxHead.brk,
                       dataRd && rxHead.par, dataRd && rxHead.frm};
  assign ovrFlag = errStatus[`ERR_OVERRUN];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      errStatus <= `ERR_RST;
    end else begin
      errStatus <= (errClearWr ? 4'h0 : errStatus) | errSet;
    end
  end

  // ========================================================================
  // Transmitter: drains the FIFO only while enabled
  uart_status_pkg::tx_state_t txState;
  logic [15:0] txCnt;
  logic [3:0] txBitIdx;
  logic [7:0] txShift;
  logic txParBit;
  wire txTick = (txCnt == BIT_LAST);
  wire txLoad = (txState == uart_status_pkg::TX_IDLE) && uartEn && !txEmpty;

  uart_sf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .oneDeep(!fifoOn),
    .push(dataWr),
    .pushData(writedata[7:0]),
    .pop(txLoad),
    .head(txHead),
    .full(txFull),
    .empty(txEmpty)
  );

  // busy on queued data, enabled or not
  assign busy = !txEmpty || (txState != uart_status_pkg::TX_IDLE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txState <= uart_status_pkg::TX_IDLE;
      txCnt <= 16'h0000;
      txBitIdx <= 4'h0;
      txShift <= 8'h00;
      txParBit <= 1'b0;
      serialOut <= 1'b1;
    end else begin
      txCnt <= txTick ? 16'h0000 : txCnt + 16'h0001;
      unique case (txState)
        uart_status_pkg::TX_IDLE: begin
          txCnt <= 16'h0000;
          serialOut <= 1'b1;
          if (txLoad) begin
            txShift <= txHead;
            txParBit <= stickPar ? !evenPar
                                 : (evenPar ? ^txHead : ~^txHead);
            serialOut <= 1'b0;
            txState <= uart_status_pkg::TX_START;
          end
        end
        uart_status_pkg::TX_START: begin
          if (txTick) begin
            serialOut <= txShift[0];
            txShift <= {1'b0, txShift[7:1]};
            txBitIdx <= 4'h1;
            txState <= uart_status_pkg::TX_DATA;
          end
        end
        uart_status_pkg::TX_DATA: begin
          if (txTick) begin
            txBitIdx <= txBitIdx + 4'h1;
            if (txBitIdx == `DATA_BITS) begin
              serialOut <= parEn ? txParBit : 1'b1;
              txState <= parEn ? uart_status_pkg::TX_PARITY
                               : uart_status_pkg::TX_STOP;
            end else begin
              serialOut <= txShift[0];
              txShift <= {1'b0, txShift[7:1]};
            end
          end
        end
        uart_status_pkg::TX_PARITY: begin
          if (txTick) begin
            serialOut <= 1'b1;
            txState <= uart_status_pkg::TX_STOP;
          end
        end
        uart_status_pkg::TX_STOP: begin
          if (txTick) txState <= uart_status_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Checks
  sequence s_break_done;
    rxDone && rxEntry.brk;
  endsequence
  sequence s_wait_high;
    (rxState == uart_status_pkg::RX_BRKWAIT) && !serialIn;
  endsequence

  a_overrun_set: assert property (@(posedge clk) disable iff (!rst_n)
    rxOverrun |=> errStatus[`ERR_OVERRUN])
    else $error("overrun not flagged");
  a_overrun_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    rxOverrun && !dataRd |=> rxFull && $stable(rxHead))
    else $error("FIFO disturbed on overrun");
  a_clear_errors: assert property (@(posedge clk) disable iff (!rst_n)
    errClearWr && errSet == 4'h0 |=> errStatus == 4'h0)
    else $error("error bits not cleared");
  a_break_zero: assert property (@(posedge clk) disable iff (!rst_n)
    s_break_done |-> rxEntry.data == 8'h00 && !rxEntry.frm)
    else $error("break char not zero");
  a_break_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_break_done ##1 s_wait_high |-> !rxDone &&
      rxState == uart_status_pkg::RX_BRKWAIT)
    else $error("receiver left break wait early");
  a_framing_flag: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rxDone) && !rxEntry.brk |-> rxEntry.frm == !$past(serialIn))
    else $error("framing flag wrong");
  a_ring_invert: assert property (@(posedge clk) disable iff (!rst_n)
    read && waitrequest && hitFlags |=>
      readdata[`FLG_RING] == !$past(ringIn_n) &&
      readdata[`FLG_CARRIER] == !$past(carrierIn_n))
    else $error("modem flag not inverted");
  a_busy_rise: assert property (@(posedge clk) disable iff (!rst_n)
    dataWr && !txFull |=> busy && !txEmpty)
    else $error("busy not raised");
  a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
    request && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");
endmodule // uart_status_flags

// ==== testbench/serial_peer.sv ====
// Remote serial device model: drives receive line and modem inputs
`timescale 1ns/1ps

// ==========================================================================
// Remote device
module serial_peer #(
  parameter int BIT_CYCLES = 8 // Clock cycles per serial bit
) (
  input wire logic clk, // System clock
  output logic lineOut, // Feeds the block's receive line
  input wire logic lineIn, // Block's transmit line
  output logic [3:0] modemN // Ring, carrier, set-ready, cts; active low
);
  // Idle: line marks high, modem lines inactive
  initial begin
    lineOut = 1'b1;
    modemN = 4'hf;
  end

  // Modem levels change right after an edge
  task automatic setModem(input logic [3:0] v);
    modemN <= v;
  endtask

  // Hold one level for whole bit times
  task automatic putBit(input logic b, input int nBits);
    lineOut <= b;
    repeat (nBits * BIT_CYCLES) @(posedge clk);
  endtask

  // Start, 8 data bits LSB first, optional parity, stop, one idle bit
  task automatic sendFrame(input logic [7:0] d, input logic hasPar,
                           input logic par, input logic stopBit);
    putBit(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      putBit(d[i], 1);
    end
    if (hasPar) begin
      putBit(par, 1);
    end
    putBit(stopBit, 1);
    putBit(1'b1, 1);
  endtask

  task automatic sendBreak(input int nBits);
    putBit(1'b0, nBits);
    putBit(1'b1, 2);
  endtask

  // Sample one transmitted frame mid-bit; returns mid stop bit
  task automatic getChar(output logic [7:0] d, output logic stopBit);
    int n;
    n = 0;
    while (lineIn !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      d[i] = lineIn;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    stopBit = lineIn;
  endtask
endmodule // serial_peer

// ==== testbench/testbench.sv ====
// Self-checking bench for the UART status and flag block
`timescale 1ns/1ps

// ==========================================================================
// Bench top
module testbench;
  localparam int DEPTH = 4;
  localparam int BITC = 8;
  logic clk, rst_n, read, write, waitrequest, serialIn, serialOut;
  logic [11:0] address;
  logic [3:0] byteenable, modemN;
  logic [31:0] writedata, readdata, dummy;
  int errCount = 0;
  int nTests = 0;
  int cycles = 0;

  uart_status_flags #(.DEPTH(DEPTH), .BIT_CYCLES(BITC)) i_uart_status_flags (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .serialIn(serialIn),
    .serialOut(serialOut), .ringIn_n(modemN[3]), .carrierIn_n(modemN[2]),
    .setReadyIn_n(modemN[1]), .clearToSendIn_n(modemN[0]));

  serial_peer #(.BIT_CYCLES(BITC)) i_serial_peer (
    .clk(clk), .lineOut(serialIn), .lineIn(serialOut), .modemN(modemN));

  // 10 MHz clock
  always #50 clk = ~clk;

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      $display("BAD %0t timeout", $time);
      printVerdict();
    end
  end

  // ========================================================================
  // Verdict
  task automatic printVerdict();
    $display("Checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ========================================================================
  // Bus access: hold request until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    rd = readdata;
    if (waitrequest !== 1'b0) begin
      errCount++;
      $display("BAD %0t bus hang", $time);
    end
    read <= 1'b0;
    write <= 1'b0;
    // Let the release land before a new request
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, dummy);
  endtask

  // Read and compare the masked bits
  task automatic chk(input logic [11:0] a, input logic [31:0] exp,
                     input logic [31:0] m);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h0, rd);
    nTests++;
    if ((rd & m) !== (exp & m)) begin
      errCount++;
      $display("BAD %0t addr %h got %h exp %h", $time, a, rd, exp);
    end
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] got;
    logic p, stopBit;
    clk = 1'b0;
    rst_n = 1'b0;
    address = 12'h000;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hf;
    writedata = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(12'h018, 32'h090, 32'h1ff); // reset flags
    chk(12'h004, 32'h0, 32'hf); // errors clear
    chk(12'h100, 32'h0, 32'hffffffff); // Unmapped reads zero
    // Modem lines one at a time low
    for (int i = 0; i < 4; i++) begin
      i_serial_peer.setModem(~(4'h1 << i));
      repeat (3) @(posedge clk);
      chk(12'h018, (i == 3) ? 32'h100 : (32'h1 << i), 32'h107);
    end
    i_serial_peer.setModem(4'hf);
    wr(12'h030, 32'h1);
    // Four parity modes, good then bad character queued together
    for (int m = 0; m < 4; m++) begin
      d = 8'hd0 + m[7:0];
      p = m[1] ? ~m[0] : (m[0] ? ^d : ~^d);
      wr(12'h02c, 32'h12 | (m[1] << 7) | (m[0] << 2));
      i_serial_peer.sendFrame(d, 1'b1, p, 1'b1);
      i_serial_peer.sendFrame(d, 1'b1, ~p, 1'b1);
      chk(12'h000, {24'h0, d}, 32'hfff); // clean entry
      chk(12'h000, {24'h2, d}, 32'hfff); // tagged entry
      chk(12'h004, 32'h2, 32'hf); // parity status
      wr(12'h004, 32'h5a5a5a5a ^ m); // any value clears
      chk(12'h004, 32'h0, 32'hf); // cleared
    end
    // Framing fault then a clean character
    wr(12'h02c, 32'h10);
    i_serial_peer.sendFrame(8'h5a, 1'b0, 1'b0, 1'b0);
    i_serial_peer.sendFrame(8'h66, 1'b0, 1'b0, 1'b1);
    chk(12'h000, 32'h15a, 32'hfff); // framing tag
    chk(12'h000, 32'h066, 32'hfff); // next entry clean
    chk(12'h004, 32'h1, 32'hf); // framing status
    wr(12'h004, 32'h0);
    // Long break, then recovery
    i_serial_peer.sendBreak(30);
    chk(12'h000, 32'h400, 32'h4ff); // one zero entry
    chk(12'h018, 32'h010, 32'h010); // nothing more stored
    chk(12'h004, 32'h4, 32'h4); // break status
    i_serial_peer.sendFrame(8'h81, 1'b0, 1'b0, 1'b1);
    chk(12'h000, 32'h081, 32'hfff); // new start accepted
    wr(12'h004, 32'h0);
    // Fill FIFO past capacity
    for (int i = 0; i <= DEPTH; i++) begin
      i_serial_peer.sendFrame(8'h10 + i[7:0], 1'b0, 1'b0, 1'b1);
    end
    chk(12'h018, 32'h040, 32'h050); // receive full
    chk(12'h004, 32'h8, 32'h8); // overrun
    for (int i = 0; i < DEPTH; i++) begin
      chk(12'h000, 32'h10 + i, 32'hff); // contents kept
    end
    chk(12'h018, 32'h010, 32'h050); // receive empty
    wr(12'h004, 32'h0);
    chk(12'h004, 32'h0, 32'hf); // overrun cleared
    // Holding-register mode
    wr(12'h02c, 32'h0);
    i_serial_peer.sendFrame(8'h77, 1'b0, 1'b0, 1'b1);
    chk(12'h018, 32'h040, 32'h050); // full after one
    i_serial_peer.sendFrame(8'h88, 1'b0, 1'b0, 1'b1);
    chk(12'h004, 32'h8, 32'h8); // overrun
    chk(12'h000, 32'h077, 32'hff); // first kept
    wr(12'h004, 32'h0);
    // Transmit side with the UART disabled
    wr(12'h030, 32'h0);
    wr(12'h000, 32'hc0);
    chk(12'h018, 32'h028, 32'h0a8); // one entry full
    wr(12'h02c, 32'h10);
    chk(12'h018, 32'h008, 32'h0a8); // FIFO has room
    for (int k = 1; k < DEPTH; k++) begin
      wr(12'h000, 32'hc0 + k);
    end
    chk(12'h018, 32'h028, 32'h0a8); // transmit full
    // Enable and collect every frame
    fork
      for (int k = 0; k < DEPTH; k++) begin
        i_serial_peer.getChar(got, stopBit);
        nTests++;
        if (got !== 8'hc0 + k[7:0] || stopBit !== 1'b1) begin
          errCount++;
          $display("BAD %0t tx char %h", $time, got);
        end
      end
      wr(12'h030, 32'h1);
    join
    chk(12'h018, 32'h088, 32'h0a8); // busy through stop bit
    repeat (BITC) @(posedge clk);
    chk(12'h018, 32'h080, 32'h0a8); // busy drops
    printVerdict();
  end
endmodule // testbench
